// file: ssf_pkg.sv
// serial status flags: shared constants, register map and state encodings
// assumes a 32-bit apb slave and one 200 mhz clock for the whole block
package ssf_pkg;
  // register byte addresses on the apb port
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_PCTRL = 8'h0c;
  localparam logic [7:0] ADDR_PDATA = 8'h10;
  localparam logic [7:0] ADDR_RDATA = 8'h14;
  localparam logic [7:0] ADDR_TDATA = 8'h18;
  // values after reset
  localparam logic [7:0] STATUS_RST = 8'h84;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] PCTRL_RST = 16'ha888;
  localparam logic [1:0] PDATA_RST = 2'h0;
  localparam logic [7:0] DATA_RST = 8'h00;
  // status bit positions
  localparam int ST_TRANSMIT_EMPTY_FLAG = 7;
  localparam int ST_RECEIVE_FULL_FLAG = 6;
  localparam int ST_ORER = 5;
  localparam int ST_FER = 4;
  localparam int ST_PER = 3;
  // mode, control and port bit positions
  localparam int MD_SYNC = 7;
  localparam int MD_PAR_EN = 5;
  localparam int MD_ODD = 4;
  localparam int MD_TWO_STOP = 3;
  localparam int MD_MP = 2;
  localparam int CT_TE = 5;
  localparam int CT_RE = 4;
  localparam int PD_SCK = 1;
  localparam int PD_BRK = 0;
  localparam logic [1:0] SCK_OUT = 2'h1;
  localparam logic [1:0] SCK_IN = 2'h2;
  localparam logic [1:0] BRK_OUT = 2'h1;
  // cycles per serial bit; rate generator is outside this block
  localparam int BIT_CYC = 16;
  localparam logic [3:0] BIT_LAST = 4'(BIT_CYC - 1);
  localparam logic [3:0] HALF_LAST = 4'(BIT_CYC / 2 - 1);
  localparam logic [2:0] IDX_LAST = 3'h7;
  // engine states, gray coded along the frame
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b011,
    RX_EXTRA = 3'b010, RX_STOP = 3'b110
  } ssf_rx_state_e;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b011,
    TX_EXTRA = 3'b010, TX_STOP = 3'b110, TX_STOP2 = 3'b111
  } ssf_tx_state_e;
endpackage

// file: ssf_flag.sv
// serial status flags: one write-zero-to-clear status flag with read record
// assumes read and write strobes are one-cycle pulses at apb completion
`timescale 1ns/1ps
module ssf_flag #(
  parameter logic INIT = 1'b0
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_init,
  input wire logic i_set,
  input wire logic i_hw_clr,
  input wire logic i_read_one,
  input wire logic i_write_zero,
  output logic o_flag,
  output logic o_sw_clr
);
  logic flag_reg, flag_next, armed_reg, armed_next;

  // set beats every clear except init, so an event in the clearing cycle is kept
  always_comb begin
    flag_next = flag_reg;
    armed_next = armed_reg;
    o_sw_clr = 1'b0;
    if (i_read_one) armed_next = 1'b1;
    if (i_write_zero) begin
      if (armed_reg) begin
        flag_next = 1'b0;
        o_sw_clr = 1'b1;
      end
      armed_next = 1'b0; // record used up by any zero write
    end
    if (i_hw_clr) begin
      flag_next = 1'b0;
      armed_next = 1'b0;
    end
    if (i_set) flag_next = 1'b1;
    if (i_init) begin
      flag_next = INIT;
      armed_next = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      flag_reg <= INIT;
      armed_reg <= 1'b0;
    end else if (i_ce) begin
      flag_reg <= flag_next;
      armed_reg <= armed_next;
    end
  end

  assign o_flag = flag_reg;

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  a_clear_armed: assert property (
    i_ce && i_write_zero && armed_reg && !i_set && !i_init |=> !flag_reg)
    else $error("armed zero write did not clear flag");
  a_keep_unarmed: assert property (
    i_ce && i_write_zero && !armed_reg && !i_set && !i_hw_clr && !i_init
    |=> flag_reg == $past(flag_reg))
    else $error("zero write without prior read changed flag");
  a_set_wins: assert property (
    i_ce && i_set && !i_init |=> flag_reg)
    else $error("set lost against clear");
endmodule

// file: ssf_rx_check.sv
// serial status flags: framing and parity check of one received character
// assumes inputs are held stable by the receiver while checked
`timescale 1ns/1ps
module ssf_rx_check (
  input wire logic [7:0] i_data,
  input wire logic i_par_bit,
  input wire logic i_stop_bit,
  input wire logic i_parity_en,
  input wire logic i_odd,
  output logic o_fer,
  output logic o_per
);
  // only the first stop bit reaches this
  assign o_fer = !i_stop_bit;
  // odd parity wants an odd count of ones over data plus parity
  assign o_per = i_parity_en && ((^{i_data, i_par_bit}) != i_odd);
endmodule

// file: ssf_serial_status.sv
// serial status flags: status register, error flags, tx/rx engines, port
// assumes apb master on i_ref_clk and pins synchronous to that clock
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ps
module ssf_serial_status
  import ssf_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_standby,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_rxd,
  output logic o_txd,
  input wire logic i_sck,
  output logic o_sck,
  output logic o_sck_oe_b
);
  logic pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic [31:0] prdata_reg, prdata_next;
  logic [7:0] mode_reg, mode_next, ctrl_reg, ctrl_next;
  logic [15:0] pctrl_reg, pctrl_next;
  logic [1:0] pdata_reg, pdata_next;
  logic [7:0] rdata_reg, rdata_next, tdata_reg, tdata_next;
  logic mp_transmit_bit_reg, mp_transmit_bit_next, mpb_reg, mpb_next, transmit_end_flag_reg, transmit_end_flag_next;
  logic txd_reg, txd_next, sck_reg, sck_next, sck_oe_b_reg, sck_oe_b_next;
  ssf_rx_state_e rx_state_reg, rx_state_next;
  logic [3:0] rx_cnt_reg, rx_cnt_next;
  logic [2:0] rx_idx_reg, rx_idx_next;
  logic [7:0] rx_shift_reg, rx_shift_next;
  logic rx_extra_reg, rx_extra_next, rx_end;
  ssf_tx_state_e tx_state_reg, tx_state_next;
  logic [3:0] tx_cnt_reg, tx_cnt_next;
  logic [2:0] tx_idx_reg, tx_idx_next;
  logic [7:0] tx_shift_reg, tx_shift_next;
  logic tx_extra_reg, tx_extra_next, tx_line, tx_load, tx_end;
  logic [7:3] set_v, hwclr_v, rd1_v, wr0_v, flag_v, swclr_v;
  logic acc, wr_done, rd_done, setup, wr_status, ctrl_zero;
  logic sync_md, par_md, mp_md, re, te, err_any, overrun, chk_fer, chk_per;
  logic sck_rd, brk_rd;

  // bus phases and mode decode
  assign setup = i_psel && !i_penable;
  assign acc = i_psel && i_penable && pready_reg;
  assign wr_done = acc && i_pwrite;
  assign rd_done = acc && !i_pwrite;
  assign wr_status = wr_done && (i_paddr == ADDR_STATUS);
  assign ctrl_zero = wr_done && (i_paddr == ADDR_CTRL) &&
    (i_pwdata[7:0] == 8'h00);
  assign sync_md = mode_reg[MD_SYNC];
  assign mp_md = mode_reg[MD_MP] && !sync_md;
  assign par_md = mode_reg[MD_PAR_EN] && !sync_md && !mp_md;
  assign re = ctrl_reg[CT_RE];
  assign te = ctrl_reg[CT_TE];
  assign err_any = flag_v[ST_ORER] || flag_v[ST_FER] || flag_v[ST_PER];
  assign overrun = rx_end && flag_v[ST_RECEIVE_FULL_FLAG];
  // pin reads through the port data register
  assign sck_rd = (pctrl_reg[3:2] == SCK_IN) ? i_sck : pdata_reg[PD_SCK];
  assign brk_rd = re ? i_rxd : pdata_reg[PD_BRK];

  ssf_rx_check u_check (
    .i_data(rx_shift_reg),
    .i_par_bit(rx_extra_reg),
    .i_stop_bit(i_rxd),
    .i_parity_en(par_md),
    .i_odd(mode_reg[MD_ODD]),
    .o_fer(chk_fer),
    .o_per(chk_per)
  );

  // flag events; only the value actually returned arms a clear
  always_comb begin
    set_v = '0;
    set_v[ST_TRANSMIT_EMPTY_FLAG] = tx_load || ctrl_zero;
    set_v[ST_RECEIVE_FULL_FLAG] = rx_end && !overrun && !chk_fer && !chk_per;
    set_v[ST_ORER] = overrun;
    set_v[ST_FER] = rx_end && chk_fer;
    set_v[ST_PER] = rx_end && chk_per;
    hwclr_v = '0;
    hwclr_v[ST_TRANSMIT_EMPTY_FLAG] = wr_done && (i_paddr == ADDR_TDATA);
    rd1_v = {5{rd_done && (i_paddr == ADDR_STATUS)}} & prdata_reg[7:3];
    wr0_v = {5{wr_status}} & ~i_pwdata[7:3];
  end

  // reset, standby, armed zero writes and, for the transmit empty flag, a tdata write; receive enable has no say
  for (genvar g = 3; g < 8; g++) begin : g_flag
    ssf_flag #(.INIT(STATUS_RST[g])) u_flag (
      .i_ref_clk(i_ref_clk),
      .i_rst_b(i_rst_b),
      .i_ce(i_ce),
      .i_init(i_standby),
      .i_set(set_v[g]),
      .i_hw_clr(hwclr_v[g]),
      .i_read_one(rd1_v[g]),
      .i_write_zero(wr0_v[g]),
      .o_flag(flag_v[g]),
      .o_sw_clr(swclr_v[g])
    );
  end

  // apb slave, config registers and status low bits
  always_comb begin
    pready_next = setup; // zero wait states: ready in the access phase
    pslverr_next = 1'b0;
    prdata_next = prdata_reg;
    mode_next = mode_reg;
    ctrl_next = ctrl_reg;
    pctrl_next = pctrl_reg;
    pdata_next = pdata_reg;
    tdata_next = tdata_reg;
    rdata_next = rdata_reg;
    mp_transmit_bit_next = mp_transmit_bit_reg;
    mpb_next = mpb_reg;
    transmit_end_flag_next = transmit_end_flag_reg;
    if (setup && !i_pwrite) begin
      if (i_paddr == ADDR_STATUS) begin
        prdata_next = {24'h0, flag_v, transmit_end_flag_reg, mpb_reg, mp_transmit_bit_reg};
      end else if (i_paddr == ADDR_MODE) begin
        prdata_next = {24'h0, mode_reg};
      end else if (i_paddr == ADDR_CTRL) begin
        prdata_next = {24'h0, ctrl_reg};
      end else if (i_paddr == ADDR_PCTRL) begin
        prdata_next = {16'h0, pctrl_reg};
      end else if (i_paddr == ADDR_PDATA) begin
        prdata_next = {30'h0, sck_rd, brk_rd};
      end else if (i_paddr == ADDR_RDATA) begin
        prdata_next = {24'h0, rdata_reg};
      end else if (i_paddr == ADDR_TDATA) begin
        prdata_next = {24'h0, tdata_reg};
      end else begin
        prdata_next = 32'h0;
        pslverr_next = 1'b1;
      end
    end else if (setup) begin
      prdata_next = 32'h0;
      pslverr_next = !(i_paddr == ADDR_STATUS || i_paddr == ADDR_MODE ||
        i_paddr == ADDR_CTRL || i_paddr == ADDR_PCTRL ||
        i_paddr == ADDR_PDATA || i_paddr == ADDR_RDATA ||
        i_paddr == ADDR_TDATA);
    end
    if (wr_done) begin
      if (i_paddr == ADDR_STATUS) begin
        mp_transmit_bit_next = i_pwdata[0]; // transmit_end_flag and mpb ignore writes
      end else if (i_paddr == ADDR_MODE) begin
        mode_next = i_pwdata[7:0];
      end else if (i_paddr == ADDR_CTRL) begin
        ctrl_next = i_pwdata[7:0];
      end else if (i_paddr == ADDR_PCTRL) begin
        pctrl_next = i_pwdata[15:0];
      end else if (i_paddr == ADDR_PDATA) begin
        pdata_next = i_pwdata[1:0];
      end else if (i_paddr == ADDR_TDATA) begin
        tdata_next = i_pwdata[7:0];
      end
    end
    // received character loads even on error, lost only on overrun
    if (rx_end && !overrun) rdata_next = rx_shift_reg;
    if (rx_end && mp_md) mpb_next = rx_extra_reg;
    if (swclr_v[ST_TRANSMIT_EMPTY_FLAG]) transmit_end_flag_next = 1'b0;
    if ((tx_end && flag_v[ST_TRANSMIT_EMPTY_FLAG]) || ctrl_zero) transmit_end_flag_next = 1'b1;
    if (i_standby) begin
      transmit_end_flag_next = STATUS_RST[2];
      mpb_next = STATUS_RST[1];
      mp_transmit_bit_next = STATUS_RST[0];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
      mode_reg <= MODE_RST;
      ctrl_reg <= CTRL_RST;
      pctrl_reg <= PCTRL_RST;
      pdata_reg <= PDATA_RST;
      tdata_reg <= DATA_RST;
      rdata_reg <= DATA_RST;
      mp_transmit_bit_reg <= STATUS_RST[0];
      mpb_reg <= STATUS_RST[1];
      transmit_end_flag_reg <= STATUS_RST[2];
    end else if (i_ce) begin
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
      mode_reg <= mode_next;
      ctrl_reg <= ctrl_next;
      pctrl_reg <= pctrl_next;
      pdata_reg <= pdata_next;
      tdata_reg <= tdata_next;
      rdata_reg <= rdata_next;
      mp_transmit_bit_reg <= mp_transmit_bit_next;
      mpb_reg <= mpb_next;
      transmit_end_flag_reg <= transmit_end_flag_next;
    end
  end

  // receiver: samples mid-bit, never starts while an error flag is up
  always_comb begin
    rx_state_next = rx_state_reg;
    rx_cnt_next = rx_cnt_reg;
    rx_idx_next = rx_idx_reg;
    rx_shift_next = rx_shift_reg;
    rx_extra_next = rx_extra_reg;
    rx_end = 1'b0;
    case (rx_state_reg)
      RX_IDLE: begin
        if (re && !err_any && !i_rxd) begin
          rx_state_next = RX_START;
          rx_cnt_next = HALF_LAST;
        end
      end
      RX_START: begin
        if (rx_cnt_reg != 4'h0) begin
          rx_cnt_next = rx_cnt_reg - 4'h1;
        end else if (i_rxd) begin
          rx_state_next = RX_IDLE; // start glitch, not a character
        end else begin
          rx_state_next = RX_DATA;
          rx_cnt_next = BIT_LAST;
          rx_idx_next = 3'h0;
        end
      end
      RX_DATA: begin
        if (rx_cnt_reg != 4'h0) begin
          rx_cnt_next = rx_cnt_reg - 4'h1;
        end else begin
          rx_shift_next = {i_rxd, rx_shift_reg[7:1]};
          rx_cnt_next = BIT_LAST;
          rx_idx_next = rx_idx_reg + 3'h1;
          if (rx_idx_reg == IDX_LAST) begin
            rx_state_next = (par_md || mp_md) ? RX_EXTRA : RX_STOP;
          end
        end
      end
      RX_EXTRA: begin
        if (rx_cnt_reg != 4'h0) begin
          rx_cnt_next = rx_cnt_reg - 4'h1;
        end else begin
          rx_extra_next = i_rxd;
          rx_cnt_next = BIT_LAST;
          rx_state_next = RX_STOP;
        end
      end
      RX_STOP: begin
        if (rx_cnt_reg != 4'h0) begin
          rx_cnt_next = rx_cnt_reg - 4'h1;
        end else begin
          rx_end = re; // second stop bit is idle line, never looked at
          rx_state_next = RX_IDLE;
        end
      end
      default: rx_state_next = RX_IDLE;
    endcase
    if (!re || i_standby) rx_state_next = RX_IDLE;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      rx_state_reg <= RX_IDLE;
      rx_cnt_reg <= 4'h0;
      rx_idx_reg <= 3'h0;
      rx_shift_reg <= DATA_RST;
      rx_extra_reg <= 1'b0;
    end else if (i_ce) begin
      rx_state_reg <= rx_state_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_idx_reg <= rx_idx_next;
      rx_shift_reg <= rx_shift_next;
      rx_extra_reg <= rx_extra_next;
    end
  end

  // transmitter; in sync mode an error flag holds off the next character
  always_comb begin
    tx_state_next = tx_state_reg;
    tx_cnt_next = tx_cnt_reg;
    tx_idx_next = tx_idx_reg;
    tx_shift_next = tx_shift_reg;
    tx_extra_next = tx_extra_reg;
    tx_load = 1'b0;
    tx_end = 1'b0;
    tx_line = 1'b1;
    if (tx_cnt_reg != 4'h0) tx_cnt_next = tx_cnt_reg - 4'h1;
    case (tx_state_reg)
      TX_IDLE: begin
        if (te && !flag_v[ST_TRANSMIT_EMPTY_FLAG] && !(sync_md && err_any)) begin
          tx_load = 1'b1;
          tx_shift_next = tdata_reg;
          // mp bit only in async mp format, else parity
          tx_extra_next = mp_md ? mp_transmit_bit_reg : (^tdata_reg) ^ mode_reg[MD_ODD];
          tx_cnt_next = BIT_LAST;
          tx_state_next = TX_START;
        end
      end
      TX_START: begin
        tx_line = 1'b0;
        if (tx_cnt_reg == 4'h0) begin
          tx_cnt_next = BIT_LAST;
          tx_idx_next = 3'h0;
          tx_state_next = TX_DATA;
        end
      end
      TX_DATA: begin
        tx_line = tx_shift_reg[0];
        if (tx_cnt_reg == 4'h0) begin
          tx_cnt_next = BIT_LAST;
          tx_shift_next = {1'b1, tx_shift_reg[7:1]};
          tx_idx_next = tx_idx_reg + 3'h1;
          if (tx_idx_reg == IDX_LAST) begin
            tx_state_next = (par_md || mp_md) ? TX_EXTRA : TX_STOP;
          end
        end
      end
      TX_EXTRA: begin
        tx_line = tx_extra_reg;
        if (tx_cnt_reg == 4'h0) begin
          tx_cnt_next = BIT_LAST;
          tx_state_next = TX_STOP;
        end
      end
      TX_STOP: begin
        if (tx_cnt_reg == 4'h0) begin
          tx_cnt_next = BIT_LAST;
          tx_end = !mode_reg[MD_TWO_STOP];
          tx_state_next = mode_reg[MD_TWO_STOP] ? TX_STOP2 : TX_IDLE;
        end
      end
      TX_STOP2: begin
        if (tx_cnt_reg == 4'h0) begin
          tx_end = 1'b1;
          tx_state_next = TX_IDLE;
        end
      end
      default: tx_state_next = TX_IDLE;
    endcase
    if (!te || i_standby) tx_state_next = TX_IDLE;
    // port data may take over the tx pin as a break driver
    txd_next = (pctrl_reg[1:0] == BRK_OUT) ? pdata_reg[PD_BRK] : tx_line;
    sck_next = pdata_reg[PD_SCK];
    sck_oe_b_next = !(pctrl_reg[3:2] == SCK_OUT);
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      tx_state_reg <= TX_IDLE;
      tx_cnt_reg <= 4'h0;
      tx_idx_reg <= 3'h0;
      tx_shift_reg <= DATA_RST;
      tx_extra_reg <= 1'b0;
      txd_reg <= 1'b1;
      sck_reg <= 1'b0;
      sck_oe_b_reg <= 1'b1;
    end else if (i_ce) begin
      tx_state_reg <= tx_state_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_idx_reg <= tx_idx_next;
      tx_shift_reg <= tx_shift_next;
      tx_extra_reg <= tx_extra_next;
      txd_reg <= txd_next;
      sck_reg <= sck_next;
      sck_oe_b_reg <= sck_oe_b_next;
    end
  end

  assign o_prdata = prdata_reg;
  assign o_pready = pready_reg;
  assign o_pslverr = pslverr_reg;
  assign o_txd = txd_reg;
  assign o_sck = sck_reg;
  assign o_sck_oe_b = sck_oe_b_reg;

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_rx_end;
    i_ce && rx_end && !i_standby;
  endsequence
  sequence s_rx_bad;
    s_rx_end ##0 (chk_fer || chk_per) && !flag_v[ST_RECEIVE_FULL_FLAG];
  endsequence

  a_fer_set: assert property (
    s_rx_end ##0 chk_fer |=> flag_v[ST_FER])
    else $error("bad stop bit did not set framing error");
  a_per_set: assert property (
    s_rx_end ##0 chk_per |=> flag_v[ST_PER] && !flag_v[ST_RECEIVE_FULL_FLAG])
    else $error("parity mismatch did not set parity error");
  a_err_loads: assert property (
    s_rx_bad |=> !flag_v[ST_RECEIVE_FULL_FLAG] && rdata_reg == $past(rx_shift_reg))
    else $error("errored character handling wrong");
  a_rx_blocked: assert property (
    err_any |-> rx_state_reg == RX_IDLE)
    else $error("receiver ran while an error flag was set");
  a_tx_sync_hold: assert property (
    sync_md && err_any && tx_state_reg == TX_IDLE |=> tx_state_reg == TX_IDLE)
    else $error("sync transmit started during error");
  a_re_keeps: assert property (
    i_ce && !re && !wr_status && !i_standby
    |=> {flag_v[ST_FER], flag_v[ST_PER], mpb_reg} ==
        $past({flag_v[ST_FER], flag_v[ST_PER], mpb_reg}))
    else $error("receive off changed held status");
  a_transmit_end_flag_set: assert property (
    i_ce && tx_end && flag_v[ST_TRANSMIT_EMPTY_FLAG] |=> transmit_end_flag_reg)
    else $error("transmit end not set at last bit");
  a_transmit_end_flag_clr: assert property (
    i_ce && swclr_v[ST_TRANSMIT_EMPTY_FLAG] && !tx_end && !i_standby |=> !transmit_end_flag_reg)
    else $error("transmit end not cleared with empty flag");
  a_mpb_capture: assert property (
    s_rx_end ##0 mp_md |=> mpb_reg == $past(rx_extra_reg))
    else $error("received mp bit not captured");
  a_mp_transmit_bit_sent: assert property (
    i_ce && tx_state_reg == TX_EXTRA && mp_md && pctrl_reg[1:0] != BRK_OUT
    |=> o_txd == $past(tx_extra_reg))
    else $error("mp transmit bit not on the line");
  a_standby_init: assert property (
    i_ce && i_standby |=> {flag_v, transmit_end_flag_reg, mpb_reg, mp_transmit_bit_reg} == STATUS_RST)
    else $error("standby did not initialise status");
endmodule

// file: ssf_remote.sv
// remote transceiver model: sends frames on rxd, samples frames on txd
// assumes 16 clocks per bit; rxd idles high like a pulled-up line
`timescale 1ns/1ps
module ssf_remote (
  input wire logic i_ref_clk,
  input wire logic i_txd,
  output logic o_rxd
);
  initial o_rxd = 1'b1;
  // n bits lsb first, start bit in bit 0, each one bit time long
  task automatic send(logic [12:0] b, int n);
    for (int i = 0; i < n; i++) begin
      o_rxd <= b[i];
      repeat (16) @(posedge i_ref_clk);
    end
    o_rxd <= 1'b1;
  endtask
  task automatic grab(int n, output logic [12:0] b, output logic ok);
    int t;
    for (t = 0; t < 400 && i_txd !== 1'b0; t++) @(posedge i_ref_clk);
    ok = t < 400;
    repeat (8) @(posedge i_ref_clk);
    for (int i = 0; i < n; i++) begin
      b[i] = i_txd;
      repeat (16) @(posedge i_ref_clk);
    end
  endtask
endmodule

// file: ssf_serial_status_tb.sv
// testbench for the serial status flags: apb and serial scenarios
// assumes the remote model on the serial lines
`timescale 1ns/1ps
module ssf_serial_status_tb;
  import ssf_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, stby = 1'b0, psel = 1'b0, pen = 1'b0;
  logic pwr = 1'b0, pready, pslverr, err, rxd, txd, ok;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [12:0] bits;
  int num_errors = 0, n_checks = 0;
  ssf_serial_status uut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_ce(1'b1),
    .i_standby(stby), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_rxd(rxd), .o_txd(txd),
    .i_sck(1'b0), .o_sck(), .o_sck_oe_b());
  ssf_remote rem (.i_ref_clk(clk), .i_txd(txd), .o_rxd(rxd));
  // 200 mhz clock
  initial forever #2.5 clk = ~clk;
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) $display("mismatch %s expected %h seen %h", nm, e, g);
    num_errors += int'(g !== e);
  endtask
  // request held until an edge sees pready; idle edge avoids re-driving
  task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
    int t;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // look at pready mid-cycle, so the next rising edge is the access edge
    for (t = 0; t < 50; t++) begin
      @(negedge clk);
      if (pready === 1'b1) break;
      @(posedge clk);
    end
    q = prdata;
    err = pslverr;
    @(posedge clk);
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
    num_errors += int'(t >= 50);
    if (t >= 50) finish_test();
  endtask
  task automatic st(logic [31:0] e);
    xfer(1'b0, ADDR_STATUS, 32'h0);
    chk("status", e, q);
  endtask
  task automatic t_framing();
    xfer(1'b1, ADDR_CTRL, 32'h10);
    rem.send({4'h0, 8'h5a, 1'b0}, 10);
    st(32'h94);
    xfer(1'b0, ADDR_RDATA, 32'h0);
    chk("rx data", 32'h5a, q);
    rem.send({4'h1, 8'h33, 1'b0}, 10);
    xfer(1'b1, ADDR_CTRL, 32'h0);
    st(32'h94);
    xfer(1'b1, ADDR_STATUS, 32'hee);
    st(32'h84);
    $display("framing test done");
  endtask
  task automatic t_parity();
    xfer(1'b1, ADDR_MODE, 32'h28);
    xfer(1'b1, ADDR_CTRL, 32'h10);
    rem.send({3'h1, 1'b0, 8'h01, 1'b0}, 12);
    xfer(1'b1, ADDR_STATUS, 32'hf6);
    st(32'h8c);
    xfer(1'b1, ADDR_STATUS, 32'hf6);
    st(32'h84);
    $display("parity test done");
  endtask
  task automatic t_mp_rx();
    xfer(1'b1, ADDR_MODE, 32'h04);
    rem.send({4'h3, 8'h3c, 1'b0}, 11);
    st(32'hc6);
    xfer(1'b1, ADDR_CTRL, 32'h0);
    st(32'hc6);
    $display("mp receive test done");
  endtask
  // data is loaded before enabling so no stale byte goes out
  task automatic t_tx();
    for (int m = 0; m < 2; m++) begin
      xfer(1'b1, ADDR_CTRL, 32'h0);
      xfer(1'b1, ADDR_STATUS, 32'h7e | 32'(m));
      st(32'h42 | 32'(m));
      xfer(1'b1, ADDR_TDATA, 32'ha5);
      xfer(1'b1, ADDR_CTRL, 32'h20);
      rem.grab(11, bits, ok);
      chk("tx frame", {20'h0, 2'h3, m[0], 8'ha5, 1'b0},
        {20'h0, ok, bits[10:0]});
      st(32'hc6 | 32'(m));
    end
    $display("transmit test done");
  endtask
  task automatic t_port();
    xfer(1'b0, 8'h1c, 32'h0);
    chk("unmapped", 32'h80000000, {err, q[30:0]});
    xfer(1'b1, ADDR_PCTRL, 32'h1);
    @(posedge clk);
    chk("txd break", 32'h0, {31'h0, txd});
    $display("port test done");
  endtask
  // reset for 16 clocks, then the scenarios in order
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_framing();
    t_parity();
    t_mp_rx();
    t_tx();
    t_port();
    finish_test();
  end
endmodule
